// >>> logic/exec_consts.svh
/*
 register offsets, field positions and reset values of the execute unit.
 assumes byte addresses on an 8-bit wishbone address bus.
*/
`ifndef EXEC_CONSTS_SVH
`define EXEC_CONSTS_SVH

`define OFF_CMD      8'h00
`define OFF_STAT     8'h04
`define OFF_IMM      8'h08
`define OFF_LIST     8'h0C
`define OFF_OPA      8'h10
`define OFF_OPB      8'h14
`define OFF_OPC      8'h18
`define OFF_FLAGS    8'h1C
`define OFF_SBP      8'h20
`define OFF_SP       8'h24
`define OFF_PC       8'h28
`define OFF_SPC      8'h2C
`define OFF_SFLAGS   8'h30
`define OFF_GPR      2'h1
`define GPR_COUNT    4'hC

`define CMD_IMM_FORM  5
`define CMD_BASE_LOAD 6
`define CMD_COND_LSB  8

`define FLG_Z 0
`define FLG_S 1
`define FLG_V 2
`define FLG_C 3
`define FLG_K 4

`define FLAGS_RST 5'h00
`define SP_RST    32'h00000000
`define PUSH_TOP  4'hB
`define PUSH_DONE 4'hF

`endif

// >>> logic/exec_pkg.sv
/*
 types of the execute unit: operation codes, sequencer states, access sizes
 and the packed state record of the core.
 assumes nothing of its surroundings.
*/
`default_nettype none
package exec_pkg;
    typedef enum logic [4:0] {
        load_upper_add, word_product_signed, word_product_unsigned, half_product,
        half_product_immediate, bitwise_negate, bit_invert, bitwise_union,
        frame_push, exception_return, arith_right_shift, shift_and_condition_bit,
        clamped_add, clamped_subtract, clamped_subtract_immediate,
        clamped_reverse_subtract, bit_force_one, condition_to_register,
        logical_left_shift, logical_right_shift, short_byte_load_signed,
        short_byte_load_unsigned, short_half_load_signed
    } op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0, ST_EXEC = 2'h1, ST_READ = 2'h3, ST_WRITE = 2'h2
    } fsm_t;

    typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_HALF = 2'h1, SZ_WORD = 2'h2} size_t;

    typedef struct packed {
        fsm_t               fsm;
        logic               ack;
        logic [31:0]        rdat;
        op_t                op;
        logic               imm_form;
        logic               base_load;
        logic [3:0]         cond;
        logic [15:0]        imm;
        logic [11:0]        list;
        logic [31:0]        a;
        logic [31:0]        b;
        logic [31:0]        c;
        logic [4:0]         flags;
        logic [31:0]        sbp;
        logic [31:0]        sp;
        logic [31:0]        pc;
        logic [31:0]        spc;
        logic [4:0]         sflags;
        logic [11:0][31:0]  gpr;
        logic [3:0]         idx;
        logic               mem_req;
        logic               mem_we;
        size_t              mem_size;
        logic [31:0]        mem_addr;
        logic [31:0]        mem_wdata;
    } core_state_t;
endpackage
`default_nettype wire

// >>> logic/exec_alu_if.sv
/*
 operand and result bundle between the core sequencer and its datapath.
 assumes both ends run on the same clock.
*/
`default_nettype none
interface exec_alu_if;
    exec_pkg::op_t op;
    logic          imm_form;
    logic [15:0]   imm;
    logic [3:0]    cond;
    logic [31:0]   a;
    logic [31:0]   b;
    logic [4:0]    flags;
    logic [31:0]   res;
    logic [31:0]   hi;
    logic [4:0]    flags_o;
    logic          wr_b;
    logic          wr_hi;
    modport alu  (input op, imm_form, imm, cond, a, b, flags,
                  output res, hi, flags_o, wr_b, wr_hi);
    modport core (output op, imm_form, imm, cond, a, b, flags,
                  input res, hi, flags_o, wr_b, wr_hi);
endinterface
`default_nettype wire

// >>> logic/exec_alu.sv
/*
 combinational datapath for register-only operations: products, logic,
 shifts, condition tests and clamped arithmetic with their flag effects.
 assumes operands are stable registers of the core.
*/
`default_nettype none
`include "exec_consts.svh"
module exec_alu (
    exec_alu_if.alu x
);
    always_comb begin
        logic [31:0] opd;
        logic [31:0] lhs;
        logic [32:0] sum;
        logic [63:0] prod;
        logic [4:0]  n;
        logic        carry;
        logic        wrap;
        logic        cond_ok;
        logic        subtract;
        opd      = x.imm_form ? {{27{x.imm[4]}}, x.imm[4:0]} : x.a;
        lhs      = x.b;
        sum      = 33'h0;
        prod     = 64'h0;
        n        = x.imm_form ? x.imm[4:0] : x.a[4:0];
        carry    = 1'b0;
        wrap     = 1'b0;
        subtract = 1'b0;
        cond_ok  = 1'b0;
        unique case (x.cond[2:0])
            3'h0: cond_ok = x.flags[`FLG_V];
            3'h1: cond_ok = x.flags[`FLG_C];
            3'h2: cond_ok = x.flags[`FLG_Z];
            3'h3: cond_ok = x.flags[`FLG_C] | x.flags[`FLG_Z];
            3'h4: cond_ok = x.flags[`FLG_S];
            3'h5: cond_ok = 1'b1;
            3'h6: cond_ok = x.flags[`FLG_S] ^ x.flags[`FLG_V];
            3'h7: cond_ok = (x.flags[`FLG_S] ^ x.flags[`FLG_V]) | x.flags[`FLG_Z];
        endcase
        cond_ok   = cond_ok ^ x.cond[3];
        x.res     = x.b;
        x.hi      = 32'h0;
        x.flags_o = x.flags;
        x.wr_b    = 1'b1;
        x.wr_hi   = 1'b0;
        unique case (x.op)
            exec_pkg::load_upper_add: x.res = x.a + {x.imm, 16'h0000};
            exec_pkg::word_product_signed,
            exec_pkg::word_product_unsigned: begin
                opd = x.imm_form ? {{23{x.imm[8]}}, x.imm[8:0]} : x.a;
                if (x.op == exec_pkg::word_product_signed) begin
                    prod = {{32{x.b[31]}}, x.b} * {{32{opd[31]}}, opd};
                end else begin
                    prod = {32'h0, x.b} * {32'h0, opd};
                end
                x.res   = prod[31:0];
                x.hi    = prod[63:32];
                x.wr_hi = 1'b1;
            end
            exec_pkg::half_product: begin
                opd   = x.imm_form ? {{27{x.imm[4]}}, x.imm[4:0]} : {{16{x.a[15]}}, x.a[15:0]};
                x.res = {{16{x.b[15]}}, x.b[15:0]} * opd;
            end
            exec_pkg::half_product_immediate:
                x.res = {{16{x.a[15]}}, x.a[15:0]} * {{16{x.imm[15]}}, x.imm};
            exec_pkg::bitwise_negate: x.res = ~x.a;
            exec_pkg::bitwise_union: x.res = x.a | (x.imm_form ? {16'h0, x.imm} : x.b);
            exec_pkg::logical_left_shift: {carry, x.res} = {1'b0, x.b} << n;
            exec_pkg::logical_right_shift: {x.res, carry} = {x.b, 1'b0} >> n;
            exec_pkg::arith_right_shift:
                {x.res, carry} = 33'($signed({x.b, 1'b0}) >>> n);
            exec_pkg::shift_and_condition_bit: x.res = {x.b[30:0], cond_ok};
            exec_pkg::condition_to_register: x.res = {31'h0, cond_ok};
            exec_pkg::clamped_add, exec_pkg::clamped_subtract,
            exec_pkg::clamped_subtract_immediate, exec_pkg::clamped_reverse_subtract: begin
                subtract = x.op != exec_pkg::clamped_add;
                if (x.op == exec_pkg::clamped_subtract_immediate) begin
                    lhs = x.a;
                    opd = {{16{x.imm[15]}}, x.imm};
                end else if (x.op == exec_pkg::clamped_reverse_subtract) begin
                    lhs = x.a;
                    opd = x.b;
                end
                sum   = subtract ? {1'b0, lhs} - {1'b0, opd} : {1'b0, lhs} + {1'b0, opd};
                wrap  = ((lhs[31] ^ opd[31]) == subtract) && (sum[31] != lhs[31]);
                carry = sum[32];
                x.res = wrap ? (lhs[31] ? 32'h80000000 : 32'h7FFFFFFF) : sum[31:0];
                x.flags_o[`FLG_K] = x.flags[`FLG_K] | wrap;
            end
            default: x.wr_b = 1'b0;
        endcase
        unique case (x.op)
            exec_pkg::bitwise_negate, exec_pkg::bitwise_union,
            exec_pkg::logical_left_shift, exec_pkg::logical_right_shift,
            exec_pkg::arith_right_shift, exec_pkg::clamped_add,
            exec_pkg::clamped_subtract, exec_pkg::clamped_subtract_immediate,
            exec_pkg::clamped_reverse_subtract: begin
                x.flags_o[`FLG_V] = wrap;
                x.flags_o[`FLG_S] = x.res[31];
                x.flags_o[`FLG_Z] = x.res == 32'h0;
                if (x.op != exec_pkg::bitwise_negate && x.op != exec_pkg::bitwise_union) begin
                    x.flags_o[`FLG_C] = carry;
                end
            end
            default: x.flags_o = x.flags;
        endcase
    end
endmodule
`default_nettype wire

// >>> logic/exec_core.sv
/*
 execute unit for a slice of a 32-bit core: a wishbone register slave holds
 operands, flags and pointers; a command write runs one operation, with a
 memory master port for byte and halfword loads, bit updates and pushes.
 assumes a classic wishbone master and a memory answering with mem_ack_i,
 both on clk_i; read data arrives right-justified.
*/
`default_nettype none
`include "exec_consts.svh"
module exec_core (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             mem_req_o,
    output logic             mem_we_o,
    output logic      [1:0]  mem_size_o,
    output logic      [31:0] mem_addr_o,
    output logic      [31:0] mem_wdata_o,
    input  wire logic [31:0] mem_rdata_i,
    input  wire logic        mem_ack_i,
    output logic             busy_o
);
    exec_pkg::core_state_t q;
    exec_pkg::core_state_t d;
    exec_alu_if            alu_bus ();

    exec_alu u_alu (
        .x (alu_bus.alu)
    );

    assign alu_bus.op       = q.op;
    assign alu_bus.imm_form = q.imm_form;
    assign alu_bus.imm      = q.imm;
    assign alu_bus.cond     = q.cond;
    assign alu_bus.a        = q.a;
    assign alu_bus.b        = q.b;
    assign alu_bus.flags    = q.flags;

    assign wb_dat_o    = q.rdat;
    assign wb_ack_o    = q.ack;
    assign mem_req_o   = q.mem_req;
    assign mem_we_o    = q.mem_we;
    assign mem_size_o  = q.mem_size;
    assign mem_addr_o  = q.mem_addr;
    assign mem_wdata_o = q.mem_wdata;
    assign busy_o      = q.fsm != exec_pkg::ST_IDLE;

    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0]  sel
    );
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old & ~m) | (nw & m);
    endfunction

    logic        wb_req;
    logic        wb_wr;
    logic        gpr_hit;
    logic [31:0] rd_word;
    logic [31:0] wv;
    logic [31:0] bit_addr;
    logic [2:0]  bit_no;
    logic [7:0]  bit_mask;
    logic [7:0]  rd_byte;

    always_comb begin
        d        = q;
        wb_req   = wb_cyc_i & wb_stb_i;
        gpr_hit  = (wb_adr_i[7:6] == `OFF_GPR) && (wb_adr_i[5:2] < `GPR_COUNT);
        bit_addr = q.imm_form ? q.a + {{16{q.imm[15]}}, q.imm} : q.a;
        bit_no   = q.imm_form ? q.imm[2:0] : q.b[2:0];
        bit_mask = 8'h01 << bit_no;
        rd_byte  = mem_rdata_i[7:0];

        // register read view, also the base of byte-lane writes
        rd_word = 32'h0;
        unique case (wb_adr_i)
            `OFF_CMD: begin
                rd_word = {20'h0, q.cond, 1'b0, q.base_load, q.imm_form, q.op};
            end
            `OFF_STAT:   rd_word = {30'h0, q.mem_req, busy_o};
            `OFF_IMM:    rd_word = {16'h0, q.imm};
            `OFF_LIST:   rd_word = {20'h0, q.list};
            `OFF_OPA:    rd_word = q.a;
            `OFF_OPB:    rd_word = q.b;
            `OFF_OPC:    rd_word = q.c;
            `OFF_FLAGS:  rd_word = {27'h0, q.flags};
            `OFF_SBP:    rd_word = q.sbp;
            `OFF_SP:     rd_word = q.sp;
            `OFF_PC:     rd_word = q.pc;
            `OFF_SPC:    rd_word = q.spc;
            `OFF_SFLAGS: rd_word = {27'h0, q.sflags};
            default: begin
                if (gpr_hit) begin
                    rd_word = q.gpr[wb_adr_i[5:2]];
                end
            end
        endcase

        // one-wait-state slave: ack follows the request by one edge
        d.ack = wb_req & ~q.ack;
        if (wb_req & ~q.ack) begin
            d.rdat = rd_word;
        end

        // writes land on the edge where the master sees ack, only while idle
        wv    = merge(rd_word, wb_dat_i, wb_sel_i);
        wb_wr = wb_req & wb_we_i & q.ack & (q.fsm == exec_pkg::ST_IDLE);
        if (wb_wr) begin
            unique case (wb_adr_i)
                `OFF_CMD: begin
                    d.op        = exec_pkg::op_t'(wv[4:0]);
                    d.imm_form  = wv[`CMD_IMM_FORM];
                    d.base_load = wv[`CMD_BASE_LOAD];
                    d.cond      = wv[`CMD_COND_LSB+:4];
                    d.idx       = `PUSH_TOP;
                    d.fsm       = exec_pkg::ST_EXEC;
                end
                `OFF_IMM:    d.imm    = wv[15:0];
                `OFF_LIST:   d.list   = wv[11:0];
                `OFF_OPA:    d.a      = wv;
                `OFF_OPB:    d.b      = wv;
                `OFF_OPC:    d.c      = wv;
                `OFF_FLAGS:  d.flags  = wv[4:0];
                `OFF_SBP:    d.sbp    = wv;
                `OFF_SP:     d.sp     = wv;
                `OFF_PC:     d.pc     = wv;
                `OFF_SPC:    d.spc    = wv;
                `OFF_SFLAGS: d.sflags = wv[4:0];
                default: begin
                    if (gpr_hit) begin
                        d.gpr[wb_adr_i[5:2]] = wv;
                    end
                end
            endcase
        end

        unique case (q.fsm)
            exec_pkg::ST_IDLE: begin
            end
            exec_pkg::ST_EXEC: begin
                d.fsm = exec_pkg::ST_IDLE;
                unique case (q.op)
                    exec_pkg::exception_return: begin
                        d.pc    = q.spc;
                        d.flags = q.sflags;
                    end
                    exec_pkg::bit_invert, exec_pkg::bit_force_one: begin
                        d.mem_req  = 1'b1;
                        d.mem_we   = 1'b0;
                        d.mem_size = exec_pkg::SZ_BYTE;
                        d.mem_addr = bit_addr;
                        d.fsm      = exec_pkg::ST_READ;
                    end
                    exec_pkg::short_byte_load_signed,
                    exec_pkg::short_byte_load_unsigned,
                    exec_pkg::short_half_load_signed: begin
                        d.mem_req  = 1'b1;
                        d.mem_we   = 1'b0;
                        d.mem_size = exec_pkg::SZ_BYTE;
                        d.fsm      = exec_pkg::ST_READ;
                        if (q.op == exec_pkg::short_byte_load_signed) begin
                            d.mem_addr = q.sbp + {25'h0, q.imm[6:0]};
                        end else if (q.op == exec_pkg::short_byte_load_unsigned) begin
                            d.mem_addr = q.sbp + {28'h0, q.imm[3:0]};
                        end else begin
                            d.mem_size = exec_pkg::SZ_HALF;
                            d.mem_addr = (q.sbp + {24'h0, q.imm[7:0]}) & 32'hFFFFFFFE;
                        end
                    end
                    exec_pkg::frame_push: begin
                        if (q.idx == `PUSH_DONE) begin
                            d.sp = q.sp - {25'h0, q.imm[4:0], 2'h0};
                            if (q.base_load) begin
                                d.sbp = q.c;
                            end
                        end else if (q.list[q.idx]) begin
                            d.sp        = q.sp - 32'h4;
                            d.mem_addr  = q.sp - 32'h4;
                            d.mem_wdata = q.gpr[q.idx];
                            d.mem_size  = exec_pkg::SZ_WORD;
                            d.mem_we    = 1'b1;
                            d.mem_req   = 1'b1;
                            d.idx       = q.idx - 4'h1;
                            d.fsm       = exec_pkg::ST_WRITE;
                        end else begin
                            d.idx = q.idx - 4'h1;
                            d.fsm = exec_pkg::ST_EXEC;
                        end
                    end
                    default: begin
                        if (alu_bus.wr_b) begin
                            d.b = alu_bus.res;
                        end
                        if (alu_bus.wr_hi) begin
                            d.c = alu_bus.hi;
                        end
                        d.flags = alu_bus.flags_o;
                    end
                endcase
            end
            exec_pkg::ST_READ: begin
                if (mem_ack_i) begin
                    unique case (q.op)
                        exec_pkg::short_byte_load_signed: begin
                            d.b = {{24{rd_byte[7]}}, rd_byte};
                        end
                        exec_pkg::short_byte_load_unsigned: begin
                            d.b = {24'h0, rd_byte};
                        end
                        exec_pkg::short_half_load_signed: begin
                            d.b = {{16{mem_rdata_i[15]}}, mem_rdata_i[15:0]};
                        end
                        default: begin
                            d.flags[`FLG_Z] = ~|(rd_byte & bit_mask);
                            d.mem_we        = 1'b1;
                            if (q.op == exec_pkg::bit_invert) begin
                                d.mem_wdata = {24'h0, rd_byte ^ bit_mask};
                            end else begin
                                d.mem_wdata = {24'h0, rd_byte | bit_mask};
                            end
                        end
                    endcase
                    if (d.mem_we) begin
                        d.fsm = exec_pkg::ST_WRITE;
                    end else begin
                        d.mem_req = 1'b0;
                        d.fsm     = exec_pkg::ST_IDLE;
                    end
                end
            end
            exec_pkg::ST_WRITE: begin
                if (mem_ack_i) begin
                    d.mem_req = 1'b0;
                    d.mem_we  = 1'b0;
                    if (q.op == exec_pkg::frame_push) begin
                        d.fsm = exec_pkg::ST_EXEC;
                    end else begin
                        d.fsm = exec_pkg::ST_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q       <= '0;
            q.flags <= `FLAGS_RST;
            q.sp    <= `SP_RST;
        end else if (ce_i) begin
            q <= d;
        end
    end
endmodule
`default_nettype wire

// >>> verif/exec_core_checker.sv
/*
 port assertions of the execute unit: bus answers, memory holds, push steps.
 assumes it is bound to exec_core, one clock and async active-low reset.
*/
`default_nettype none
module exec_core_checker (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        ce_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        mem_req_o,
    input wire logic        mem_we_o,
    input wire logic [1:0]  mem_size_o,
    input wire logic [31:0] mem_addr_o,
    input wire logic        mem_ack_i,
    input wire logic        busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic        hv_q;
    logic [31:0] lw_q;
    wire         take = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
    // last pushed word address within one operation
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hv_q <= 1'b0;
            lw_q <= 32'h0;
        end else if (!busy_o) begin
            hv_q <= 1'b0;
        end else if (mem_ack_i && mem_we_o && mem_size_o == 2'h2) begin
            hv_q <= 1'b1;
            lw_q <= mem_addr_o;
        end
    end
    a_ack_one_shot: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    a_ack_answers: assert property (take |=> wb_ack_o)
        else $error("request not acked");
    a_rdat_holds: assert property (!wb_ack_o |-> $stable(wb_dat_o))
        else $error("read data moved without ack");
    a_mem_holds: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)
        && $stable(mem_we_o) && $stable(mem_size_o)) else $error("memory request moved");
    a_rmw_write: assert property ((mem_req_o && mem_ack_i && !mem_we_o) ##1 mem_req_o |->
        mem_we_o && mem_size_o == 2'h0 && $stable(mem_addr_o)) else $error("bad bit write");
    a_half_even: assert property (mem_req_o && mem_size_o == 2'h1 |-> !mem_addr_o[0])
        else $error("odd halfword address");
    a_push_step: assert property (mem_req_o && mem_we_o && mem_size_o == 2'h2 && hv_q |->
        mem_addr_o == lw_q - 32'h4) else $error("push step not four");
    a_cmd_busy: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && !busy_o && ce_i
        |-> ##[1:2] busy_o) else $error("command did not start");
    cover property ($rose(busy_o));
    cover property (mem_req_o && mem_we_o && mem_size_o == 2'h2);
    cover property (mem_ack_i && !mem_we_o && mem_size_o == 2'h1);
endmodule
bind exec_core exec_core_checker chk_i (.*);
`default_nettype wire

// >>> verif/cpu_execute_ops_m_to_s_tb.sv
/*
 self-checking bench of the execute unit: wishbone tasks and a byte memory.
 assumes exec_core with its checker bound; the bench answers the memory port.
*/
`default_nettype none
module cpu_execute_ops_m_to_s_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, mem_rdata_i = 32'h0, rd_v, wb_dat_o, mem_addr_o, mem_wdata_o;
    logic        mem_ack_i = 1'b0, gap_q = 1'b0, wb_ack_o, mem_req_o, mem_we_o, busy_o;
    logic [1:0]  mem_size_o;
    logic [7:0]  mem [256];
    logic [7:0]  cond_tbl = 8'hFA;
    int          num_errors = 0, n_tests = 0;
    exec_core uut (.*);
    always #12.5 clk_i = ~clk_i;
    // memory answers every other cycle; idle read data keeps changing
    always @(posedge clk_i) begin
        mem_ack_i <= 1'b0;
        mem_rdata_i <= ~mem_rdata_i;
        gap_q <= ~gap_q;
        if (mem_req_o === 1'b1 && !mem_ack_i && gap_q) begin
            mem_ack_i <= 1'b1;
            mem_rdata_i <= {mem[mem_addr_o[7:0] + 8'h3], mem[mem_addr_o[7:0] + 8'h2],
                mem[mem_addr_o[7:0] + 8'h1], mem[mem_addr_o[7:0]]}
                & (mem_size_o == 2'h0 ? 32'hFF : mem_size_o == 2'h1 ? 32'hFFFF : 32'hFFFFFFFF);
            for (int k = 0; k < 4; k++)
                if (mem_we_o && k < (1 << mem_size_o))
                    mem[mem_addr_o[7:0] + 8'(k)] <= mem_wdata_o[8*k +: 8];
        end
    end
    task results;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        for (k = 0; k < 50; k++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        rd_v = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (k == 50) begin
            num_errors++;
            results;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask
    task waitb;
        int k;
        for (k = 0; k < 300 && (k < 3 || busy_o !== 1'b0); k++) @(negedge clk_i);
        if (k == 300) begin
            num_errors++;
            results;
        end
    endtask
    task op(input logic [11:0] cm, input logic [31:0] a, b, input logic [15:0] im,
            input logic [4:0] fl, input logic [31:0] eb, ec, input logic [4:0] ef);
        wr(8'h10, a);
        wr(8'h14, b);
        wr(8'h18, 32'h0);
        wr(8'h08, {16'h0, im});
        wr(8'h1C, {27'h0, fl});
        wr(8'h00, {20'h0, cm});
        waitb;
        rd(8'h14);
        chk(rd_v, eb);
        rd(8'h18);
        chk(rd_v, ec);
        rd(8'h1C);
        chk(rd_v, {27'h0, ef});
    endtask
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = {i[3:0], i[7:4]};
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(8'h1C);
        chk(rd_v, 32'h0);
        wb_sel_i <= 4'h2;
        wr(8'h10, 32'hAABBCCDD);
        wb_sel_i <= 4'hF;
        rd(8'h10);
        chk(rd_v, 32'h0000CC00);
        wr(8'hFC, 32'h12345678);
        rd(8'hFC);
        chk(rd_v, 32'h0);
        op(12'h020, 32'h1234, 0, 16'hABCD, 5'h1F, 32'hABCD1234, 0, 5'h1F);
        op(12'h001, 32'hFFFFFFFE, 32'h3, 0, 5'h0A, 32'hFFFFFFFA, 32'hFFFFFFFF, 5'h0A);
        op(12'h021, 0, 32'h5, 16'h01FF, 5'h0A, 32'hFFFFFFFB, 32'hFFFFFFFF, 5'h0A);
        op(12'h002, 32'hFFFFFFFF, 32'h2, 0, 5'h15, 32'hFFFFFFFE, 32'h1, 5'h15);
        op(12'h022, 0, 32'h2, 16'h01FF, 5'h15, 32'hFFFFFFFE, 32'h1, 5'h15);
        op(12'h003, 32'h1FFFF, 32'h77770003, 0, 5'h1F, 32'hFFFFFFFD, 0, 5'h1F);
        op(12'h023, 0, 32'h4, 16'h1F, 5'h00, 32'hFFFFFFFC, 0, 5'h00);
        op(12'h024, 32'h3, 0, 16'hFFFF, 5'h0A, 32'hFFFFFFFD, 0, 5'h0A);
        op(12'h005, 32'hFFFFFFFF, 32'h9, 0, 5'h1E, 32'h0, 0, 5'h19);
        op(12'h007, 32'hF000, 32'h0F000000, 0, 5'h0F, 32'h0F00F000, 0, 5'h08);
        op(12'h027, 32'h80000000, 0, 16'h8001, 5'h04, 32'h80008001, 0, 5'h02);
        op(12'h00A, 32'h24, 32'h80000018, 0, 5'h14, 32'hF8000001, 0, 5'h1A);
        op(12'h032, 0, 32'hC0000000, 16'h1, 5'h00, 32'h80000000, 0, 5'h0A);
        op(12'h013, 32'h1F, 32'h80000001, 0, 5'h0C, 32'h1, 0, 5'h00);
        op(12'h50B, 0, 32'h3, 0, 5'h0A, 32'h7, 0, 5'h0A);
        op(12'hD0B, 0, 32'h3, 0, 5'h0A, 32'h6, 0, 5'h0A);
        for (int c = 0; c < 16; c++)
            op({c[3:0], 8'h11}, 0, 32'h5, 0, 5'h0A, {31'h0, c[3] ^ cond_tbl[c[2:0]]}, 0, 5'h0A);
        op(12'h00C, 32'h7FFFFFFF, 32'h1, 0, 5'h00, 32'h7FFFFFFF, 0, 5'h14);
        op(12'h00D, 32'h1, 32'h80000000, 0, 5'h00, 32'h80000000, 0, 5'h16);
        op(12'h00F, 32'h5, 32'h3, 0, 5'h10, 32'h2, 0, 5'h10);
        op(12'h02E, 32'h1, 0, 16'hFFFF, 5'h00, 32'h2, 0, 5'h08);
        wr(8'h20, 32'h10);
        op(12'h014, 0, 0, 16'hFF, 5'h0A, 32'hFFFFFFF8, 0, 5'h0A);
        op(12'h015, 0, 0, 16'hFF, 5'h0A, 32'hF1, 0, 5'h0A);
        op(12'h016, 0, 0, 16'hFF, 5'h0A, 32'hFFFFF0E0, 0, 5'h0A);
        op(12'h006, 32'h40, 32'hA, 0, 5'h01, 32'hA, 0, 5'h00);
        chk(mem[8'h40], 32'h0);
        op(12'h010, 32'h41, 32'hB, 0, 5'h1E, 32'hB, 0, 5'h1F);
        chk(mem[8'h41], 32'h1C);
        wr(8'h2C, 32'h1234);
        wr(8'h30, 32'h15);
        op(12'h009, 0, 0, 0, 5'h0A, 0, 0, 5'h15);
        rd(8'h28);
        chk(rd_v, 32'h1234);
        wr(8'h24, 32'h80);
        wr(8'h0C, 32'h005);
        wr(8'h40, 32'h88776655);
        wr(8'h48, 32'h44332211);
        wr(8'h18, 32'hBEEF0000);
        wr(8'h08, 32'h3);
        wr(8'h00, 32'h048);
        ce_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        ce_i <= 1'b1;
        waitb;
        chk({mem[8'h7F], mem[8'h7E], mem[8'h7D], mem[8'h7C]}, 32'h44332211);
        chk({mem[8'h7B], mem[8'h7A], mem[8'h79], mem[8'h78]}, 32'h88776655);
        rd(8'h24);
        chk(rd_v, 32'h6C);
        rd(8'h20);
        chk(rd_v, 32'hBEEF0000);
        results;
    end
endmodule
`default_nettype wire
